/* hdl/sbt_pkg.sv */
// Package for the boundary-scan test port: states, instructions, widths.
// Assumes a single system clock that oversamples the test clock.
package sbt_pkg;
   // ======================================
   // Controller states
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
      ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
      ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } sbt_state_t;
   // ======================================
   // Instruction register
   localparam int IR_W = 3;
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
   localparam logic [2:0] INS_SAMPLE = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   // ======================================
   // Data registers
   localparam int ID_W = 32;
   localparam logic [31:0] ID_CODE = 32'h0000_0001; // arbitrary value
   localparam int BSR_W = 8;
   localparam int RESET_ONES = 5;
endpackage

/* hdl/sbt_sync.sv */
// Two-flop synchroniser with reset value one.
// Assumes input from another clock domain.
`timescale 1ns/100ps
`default_nettype none
module sbt_sync (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_async,
   output logic o_sync
);
   logic meta;
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         meta <= 1'b1;
         o_sync <= 1'b1;
      end else if (i_ce) begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule // sbt_sync
`default_nettype wire

/* hdl/sbt_tap.sv */
// Boundary-scan test access port controller with IR, bypass, ID and boundary register.
// Assumes i_clk_sys much faster than the test clock; pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
// Function
// R1 - Inputs are sampled at test-clock rise and outputs change only at test-clock fall; o_instr changes at a rise instead.
// R2 - Mode select sampled at each rise is the only input that steers the controller.
// R3 - An undriven mode select acts as a logic one.
// R4 - An undriven data input shifts in ones.
// R5 - Exactly one register, picked by state and instruction, sits between data in and out.
// R6 - Data out is driven only in shift states, from the selected register end, at falls.
// R7 - Five rises with mode select high always reach Test-Logic-Reset.
// R8 - The port resets at power-up and does nothing while no test clock runs.
// R9 - The memory function is untouched when the port is unused.
// R10 - States, instruction loading and data shifting follow the boundary-scan standard.
// R11 - The instruction register is three bits and loads only while in the serial path.
// R12 - Test-Logic-Reset presets the instruction to identification read.
// R13 - Capture-IR loads 01 into the two low instruction bits.
// R14 - The 32-bit identification register shifts bit 0 out first.
// R15 - Sixteen states, instruction takes effect at Update-IR, capture at Capture-DR.
module sbt_tap
   import sbt_pkg::*;
#(
   parameter int P_BSR_W = sbt_pkg::BSR_W
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tms_oe,
   input wire logic i_tdi,
   input wire logic i_tdi_oe,
   input wire logic [P_BSR_W-1:0] i_pins,
   output logic o_tdo,
   output logic o_tdo_oe,
   output logic [sbt_pkg::IR_W-1:0] o_instr,
   output logic o_test_reset
);
   import sbt_pkg::*;
   // ======================================
   // Pin resolution and synchronisers
   logic tms_pin, tdi_pin, tck_s, tms_s, tdi_s, tck_d;
   assign tms_pin = i_tms_oe ? i_tms : 1'b1; // R3
   assign tdi_pin = i_tdi_oe ? i_tdi : 1'b1; // R4
   sbt_sync u_tck (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce), .i_async(i_tck),
      .o_sync(tck_s));
   sbt_sync u_tms (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce), .i_async(tms_pin),
      .o_sync(tms_s));
   sbt_sync u_tdi (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce), .i_async(tdi_pin),
      .o_sync(tdi_s));
   // Memory-side pins cross from another clock
   logic [P_BSR_W-1:0] pins_s;
   for (genvar g = 0; g < P_BSR_W; g++) begin : g_pin_sync
      sbt_sync u_pin (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce),
         .i_async(i_pins[g]), .o_sync(pins_s[g]));
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         tck_d <= 1'b1;
      end else if (i_ce) begin
         tck_d <= tck_s;
      end
   end
   logic rise, fall;
   assign rise = i_ce && tck_s && !tck_d; // R1 R8
   assign fall = i_ce && !tck_s && tck_d; // R1
   // ======================================
   // Controller
   sbt_state_t state, next_state;
   always_comb begin
      case (state) // R2 R10 R15
         ST_RESET: next_state = tms_s ? ST_RESET : ST_IDLE;
         ST_IDLE: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: next_state = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: next_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: next_state = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
         ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_state = tms_s ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: next_state = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: next_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: next_state = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
         ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
         default: next_state = ST_RESET;
      endcase
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         state <= ST_RESET; // R8
      end else if (rise) begin
         state <= next_state; // R7
      end
   end
   // ======================================
   // Instruction register
   logic [IR_W-1:0] ir_shift;
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ir_shift <= INS_IDCODE;
         o_instr <= INS_IDCODE;
      end else if (rise) begin
         if (next_state == ST_RESET) begin
            o_instr <= INS_IDCODE; // R12
         end else if (state == ST_UPD_IR) begin
            o_instr <= ir_shift; // R15
         end
         if (state == ST_CAP_IR) begin
            ir_shift <= {{(IR_W-2){1'b0}}, IR_CAPTURE}; // R13
         end else if (state == ST_SHIFT_IR) begin
            ir_shift <= {tdi_s, ir_shift[IR_W-1:1]}; // R11
         end
      end
   end
   // ======================================
   // Data registers
   logic [ID_W-1:0] id_sr;
   logic [P_BSR_W-1:0] bsr;
   logic byp;
   function automatic logic uses_bsr(input logic [IR_W-1:0] ins);
      uses_bsr = (ins == INS_EXTEST) || (ins == INS_SAMPLE) || (ins == INS_SAMPLE_Z);
   endfunction
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         id_sr <= '0;
         bsr <= '0;
         byp <= 1'b0;
      end else if (rise) begin
         if (state == ST_CAP_DR) begin // R15
            id_sr <= ID_CODE;
            byp <= 1'b0;
            if (uses_bsr(o_instr)) begin
               bsr <= pins_s;
            end
         end else if (state == ST_SHIFT_DR) begin // R5
            if (o_instr == INS_IDCODE) begin
               id_sr <= {tdi_s, id_sr[ID_W-1:1]}; // R14
            end else if (uses_bsr(o_instr)) begin
               bsr <= {tdi_s, bsr[P_BSR_W-1:1]};
            end else begin
               byp <= tdi_s;
            end
         end
      end
   end
   // ======================================
   // Serial output at test-clock fall
   logic tdo_src;
   always_comb begin
      if (state == ST_SHIFT_IR) begin // R5
         tdo_src = ir_shift[0];
      end else if (o_instr == INS_IDCODE) begin
         tdo_src = id_sr[0]; // R14
      end else if (uses_bsr(o_instr)) begin
         tdo_src = bsr[0];
      end else begin
         tdo_src = byp;
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0; // R9
         o_test_reset <= 1'b1;
      end else if (fall) begin
         o_tdo <= tdo_src; // R6
         o_tdo_oe <= (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR); // R6
         o_test_reset <= (state == ST_RESET);
      end
   end
   // ======================================
   // Assertions
   // Run of rises with mode select high
   logic [2:0] tms_high_cnt;
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         tms_high_cnt <= 3'h0;
      end else if (rise) begin
         if (!tms_s) begin
            tms_high_cnt <= 3'h0;
         end else if (tms_high_cnt != 3'(RESET_ONES)) begin
            tms_high_cnt <= tms_high_cnt + 3'h1;
         end
      end
   end
   sequence s_fifth_high;
      rise && tms_s && (tms_high_cnt == 3'(RESET_ONES - 1));
   endsequence
   property p_five_high;
      @(posedge i_clk_sys) disable iff (i_reset)
      s_fifth_high |=> state == ST_RESET;
   endproperty
   a_five_high: assert property (p_five_high) else $error("five high rises missed reset"); // R7
   property p_reset_state;
      @(posedge i_clk_sys) disable iff (i_reset)
      (rise && state == ST_SEL_IR && tms_s) |=> state == ST_RESET;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("no reset from select-IR"); // R7
   property p_hold_reset;
      @(posedge i_clk_sys) disable iff (i_reset)
      (rise && state == ST_RESET && tms_s) |=> state == ST_RESET;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("left reset with mode high"); // R2
   property p_ir_preset;
      @(posedge i_clk_sys) disable iff (i_reset)
      (rise && next_state == ST_RESET) |=> o_instr == INS_IDCODE;
   endproperty
   a_ir_preset: assert property (p_ir_preset) else $error("instruction not preset"); // R12
   property p_ir_capture;
      @(posedge i_clk_sys) disable iff (i_reset)
      (rise && state == ST_CAP_IR) |=> ir_shift[1:0] == IR_CAPTURE;
   endproperty
   a_ir_capture: assert property (p_ir_capture) else $error("capture pattern wrong"); // R13
   property p_tdo_only_fall;
      @(posedge i_clk_sys) disable iff (i_reset)
      !fall |=> $stable(o_tdo) && $stable(o_tdo_oe);
   endproperty
   a_tdo_only_fall: assert property (p_tdo_only_fall) else $error("output moved off fall"); // R1
   property p_state_only_rise;
      @(posedge i_clk_sys) disable iff (i_reset)
      !rise |=> $stable(state);
   endproperty
   a_state_only_rise: assert property (p_state_only_rise) else $error("state moved off rise"); // R8
   property p_oe_shift;
      @(posedge i_clk_sys) disable iff (i_reset)
      fall |=> o_tdo_oe == ($past(state) == ST_SHIFT_DR || $past(state) == ST_SHIFT_IR);
   endproperty
   a_oe_shift: assert property (p_oe_shift) else $error("output enable wrong"); // R6
   property p_instr_update;
      @(posedge i_clk_sys) disable iff (i_reset)
      (rise && state != ST_UPD_IR && next_state != ST_RESET) |=> $stable(o_instr);
   endproperty
   a_instr_update: assert property (p_instr_update) else $error("instruction changed early"); // R15
   property p_id_lsb;
      @(posedge i_clk_sys) disable iff (i_reset)
      (rise && state == ST_CAP_DR && o_instr == INS_IDCODE) |=> id_sr[0] == ID_CODE[0];
   endproperty
   a_id_lsb: assert property (p_id_lsb) else $error("id bit 0 not first"); // R14
endmodule // sbt_tap
`default_nettype wire

/* tb/sbt_host_model.sv */
// Scan controller model: drives test clock, mode select and data in.
// Assumes the bench system clock; one step is one 800 ns test-clock period.
`timescale 1ns/100ps
`default_nettype none
module sbt_host_model (
   input wire logic i_clk_sys,
   input wire logic i_tdo,
   input wire logic i_tdo_oe,
   output logic o_tck = 1'b0,
   output logic o_tms = 1'b1,
   output logic o_tms_oe = 1'b1,
   output logic o_tdi = 1'b1,
   output logic o_tdi_oe = 1'b1
);
   // ======================================
   // Clock still between steps; released pins toggle
   task automatic step(input logic tms, tdi, input logic [1:0] fl, output logic [2:0] r);
      @(posedge i_clk_sys);
      o_tms <= fl[0] ? ~o_tms : tms;
      o_tms_oe <= ~fl[0];
      o_tdi <= fl[1] ? ~o_tdi : tdi;
      o_tdi_oe <= ~fl[1];
      repeat (3) @(posedge i_clk_sys);
      o_tck <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      r[1:0] = {i_tdo_oe, i_tdo};
      repeat (2) @(posedge i_clk_sys);
      r[2] = i_tdo;
      o_tck <= 1'b0;
   endtask
endmodule // sbt_host_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the boundary-scan test port.
// Assumes sbt_pkg, sbt_tap and sbt_host_model compile first.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import sbt_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic i_ce = 1'b1;
   logic [7:0] i_pins = 8'h00;
   logic i_tck, i_tms, i_tms_oe, i_tdi, i_tdi_oe, o_tdo, o_tdo_oe, o_test_reset;
   logic [2:0] o_instr;
   logic [31:0] d;
   int fails = 0, samples_checked = 0;
   always #50 i_clk_sys = ~i_clk_sys;
   sbt_tap i_sbt_tap (.i_clk_sys, .i_reset, .i_ce, .i_tck, .i_tms, .i_tms_oe, .i_tdi,
      .i_tdi_oe, .i_pins, .o_tdo, .o_tdo_oe, .o_instr, .o_test_reset);
   sbt_host_model i_sbt_host_model (.i_clk_sys, .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe),
      .o_tck(i_tck), .o_tms(i_tms), .o_tms_oe(i_tms_oe), .o_tdi(i_tdi), .o_tdi_oe(i_tdi_oe));
   // ======================================
   // Shared tasks and scenarios
   task automatic chk(input logic [31:0] got, exp, input string m);
      samples_checked++;
      fails += int'(got !== exp);
      if (got !== exp) $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic nav(input logic [7:0] seq, input int n, input logic [1:0] fl = 2'b00);
      logic [2:0] r;
      for (int i = 0; i < n; i++) i_sbt_host_model.step(seq[i], 1'b0, fl, r);
      repeat (5) @(posedge i_clk_sys);
   endtask
   task automatic shift(input int n, input logic [31:0] din, input logic fl);
      logic [2:0] r;
      d = '0;
      for (int i = 0; i < n; i++) begin
         i_sbt_host_model.step(i == n - 1, din[i], {fl, 1'b0}, r);
         d[i] = r[0];
         chk(32'(r[2:1]), 32'({r[0], 1'b1}), "shift out");
      end
      repeat (5) @(posedge i_clk_sys);
      chk(32'(o_tdo_oe), 32'h0, "out on in exit");
   endtask
   task automatic load_ir(input logic [2:0] code);
      logic [2:0] was;
      was = o_instr;
      nav(8'h03, 4);
      shift(3, 32'(code), 1'b0);
      chk(32'(d[1:0]), 32'(IR_CAPTURE), "ir capture");
      chk(32'(o_instr), 32'(was), "early instr");
      nav(8'h01, 2);
      chk(32'(o_instr), 32'(code), "instr load");
   endtask
   task automatic t_idcode;
      repeat (40) @(posedge i_clk_sys);
      chk(32'({o_instr, o_test_reset, o_tdo_oe}), 32'({INS_IDCODE, 2'b10}), "idle");
      nav(8'h02, 4);
      shift(32, 32'h0, 1'b0);
      chk(d, ID_CODE, "id code");
      nav(8'h01, 2);
   endtask
   task automatic t_bypass;
      load_ir(INS_BYPASS);
      nav(8'h01, 3);
      shift(4, 32'hA, 1'b0);
      chk(d, 32'h4, "bypass");
      nav(8'h05, 5);
      shift(3, 32'h0, 1'b1);
      chk(d, 32'h6, "tdi float");
      nav(8'h00, 1);
      for (int i = 0; i < 5; i++) begin
         nav(8'h00, 1, 2'b01);
         chk(32'(o_test_reset), 32'(i == 4), "tms float");
      end
      chk(32'(o_instr), 32'(INS_IDCODE), "reset instr");
   endtask
   task automatic t_boundary;
      nav(8'h00, 1);
      for (int k = 0; k < 3; k++) begin
         i_pins <= 8'hA5 ^ (8'h11 << k);
         load_ir(k == 0 ? INS_EXTEST : k == 1 ? INS_SAMPLE_Z : INS_SAMPLE);
         nav(8'h01, 3);
         shift(8, 32'h0, 1'b0);
         chk(d, 32'(i_pins), "boundary");
         nav(8'h01, 2);
      end
   endtask
   task automatic t_freeze;
      i_ce <= 1'b0;
      nav(8'h1F, 5);
      chk(32'({o_instr, o_test_reset}), 32'({INS_SAMPLE, 1'b0}), "frozen");
      i_ce <= 1'b1;
      nav(8'h1F, 5);
      chk(32'({o_instr, o_test_reset}), 32'({INS_IDCODE, 1'b1}), "thaw reset");
   endtask
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      t_idcode();
      t_bypass();
      t_boundary();
      t_freeze();
      end_of_test();
   end
   initial begin
      repeat (8000) @(posedge i_clk_sys);
      fails++;
      end_of_test();
   end
   task automatic end_of_test;
      $display("fails %0d samples_checked %0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
endmodule // tb
`default_nettype wire
